// ==== pkg/hcs_pkg.sv ====
// Shared constants and carrier types for the hub strap configuration selector
package hcs_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PORTS = 3;
    localparam int STRAP_W = 13;
    localparam int FEAT_W = 10;

    // ************************************************************
    // Select strap codes, written as {select bit 1, select bit 0}
    // ************************************************************
    localparam logic [1:0] SEL_SELF = 2'h0;
    localparam logic [1:0] SEL_SMB = 2'h1;
    localparam logic [1:0] SEL_BUS = 2'h2;
    localparam logic [1:0] SEL_EEPROM = 2'h3;

    // ************************************************************
    // Reset values and fixed addresses
    // ************************************************************
    localparam logic [STRAP_W-1:0] STRAP_RST = 13'h0000;
    // Internal keeper direction per pin, 1 = pull up
    localparam logic [STRAP_W-1:0] STRAP_PULL_UP = 13'h0000;
    localparam logic [7:0] SMB_END_ADDR = 8'hff;
    localparam logic VSM_ACCEPT_RST = 1'b1;
    localparam logic EC_ENABLE_RST = 1'b0;
    localparam logic RESUME_ENABLE_RST = 1'b0;
    localparam logic PASS_ENABLE_RST = 1'b0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        HCS_M_NONE,
        HCS_M_SELF,
        HCS_M_BUS,
        HCS_M_EEPROM,
        HCS_M_SMB,
        HCS_M_INVALID
    } hcs_method_t;

    typedef enum logic [1:0] {
        HCS_OTP_SINGLE,
        HCS_OTP_DIFF,
        HCS_OTP_REDUNDANT,
        HCS_OTP_DIFF_REDUNDANT
    } hcs_otp_t;

    typedef enum logic [2:0] {
        HCS_VSM_EC_ENABLE,
        HCS_VSM_EC_DISABLE,
        HCS_VSM_RESUME_ENABLE,
        HCS_VSM_RESUME_DISABLE,
        HCS_VSM_HUB_RESET
    } hcs_vsm_t;

    typedef enum logic [2:0] {
        HCS_TW_PASS_ENABLE,
        HCS_TW_PASS_DISABLE,
        HCS_TW_WRITE,
        HCS_TW_READ,
        HCS_TW_START,
        HCS_TW_STOP
    } hcs_tw_t;

    typedef struct packed {
        logic [1:0] cfg_sel;
        logic [1:0] fixed_port_count_strap;
        logic [PORTS-1:0] downstream_charge_enable_strap;
        logic [PORTS-1:0] port_minus_line_disable;
        logic [PORTS-1:0] port_plus_line_disable;
    } hcs_straps_t;

    typedef struct packed {
        logic self_powered;
        logic [PORTS-1:0] fixed_port;
        logic [PORTS-1:0] charge_support;
        logic [PORTS-1:0] port_disable;
    } hcs_feat_t;

endpackage

// ==== rtl/hcs_strap_latch.sv ====
// One-shot capture register for strap levels at reset release
`timescale 1ns/1ps
module hcs_strap_latch #(
    parameter int W = 14
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic done
);

    // ************************************************************
    // Capture on the first edge after release, then freeze
    // ************************************************************
    // Frozen after capture so later pin driving cannot leak back in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            done <= 1'b0;
        end else begin
            if (!done) begin
                q <= d;
            end
            done <= 1'b1;
        end
    end

endmodule

// ==== rtl/hcs_strap_select.sv ====
// Strap capture, configuration method selection and feature decode
`timescale 1ns/1ps
// Function
// - Method chosen from data line and selects
// - Select 00: straps, OTP, self-powered
// - Select 10: straps, OTP, bus-powered
// - Data high, select 11: EEPROM load
// - Data high, select 01: wait SMBus; low invalid
// - Strap pins undriven while reset held
// - Strap levels captured at reset release
// - Internal keeper on every strap pin
// - Fixed port code marks attached ports
// - Suspend led polarity from fixed code
// - Local power detect uses register setting
// - Charge strap high reports charging support
// - Port off only if both lines high
// - Vendor messages accepted by default
// - OTP over USB single-ended only
// - SMBus config writes only before attach
// - Two-wire commands other than pass enable/disable passed through uninterpreted
module hcs_strap_select #(
    parameter int PORTS = 3
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input hcs_pkg::hcs_straps_t STRAP_PIN_IN,
    output hcs_pkg::hcs_straps_t STRAP_PIN_OUT,
    output logic [hcs_pkg::STRAP_W-1:0] STRAP_PIN_OE,
    output logic [hcs_pkg::STRAP_W-1:0] STRAP_PULL_EN,
    output logic [hcs_pkg::STRAP_W-1:0] STRAP_PULL_UP,
    input wire logic SDA_IN,
    input hcs_pkg::hcs_straps_t FUNC_OUT,
    input wire logic SUSPEND_ACTIVE,
    input wire logic LOCAL_POWER_DETECT,
    input hcs_pkg::hcs_feat_t CFG_REG_FEAT,
    input wire logic EE_LOAD_DONE,
    output hcs_pkg::hcs_method_t CFG_METHOD,
    output logic EE_LOAD_REQ,
    output logic SMB_CFG_WAIT,
    output logic CFG_DONE,
    output logic CFG_INVALID,
    output logic STRAPS_USED,
    output hcs_pkg::hcs_feat_t FEATURES,
    input wire logic HUB_ATTACHED,
    input wire logic SMB_WR_VALID,
    input wire logic [7:0] SMB_WR_ADDR,
    input wire logic [7:0] SMB_WR_DATA,
    output logic CFG_WR_VALID,
    output logic [7:0] CFG_WR_ADDR,
    output logic [7:0] CFG_WR_DATA,
    input wire logic VSM_VALID,
    input hcs_pkg::hcs_vsm_t VSM_CMD,
    input wire logic VSM_BLOCK,
    output logic EC_ENABLE,
    output logic SPECIAL_RESUME,
    output logic HUB_RESET_REQ,
    input wire logic OTP_MODE_SET,
    input wire logic OTP_FROM_USB,
    input hcs_pkg::hcs_otp_t OTP_MODE_REQ,
    output hcs_pkg::hcs_otp_t OTP_MODE,
    input wire logic PT_VALID,
    input hcs_pkg::hcs_tw_t PT_CMD,
    input wire logic [7:0] PT_DATA,
    output logic PT_ENABLED,
    output logic TW_VALID,
    output hcs_pkg::hcs_tw_t TW_CMD,
    output logic [7:0] TW_DATA
);

    // ************************************************************
    // Elaboration check
    // ************************************************************
    // Fixed port code is two bits wide, so only three ports decode
    if (PORTS != hcs_pkg::PORTS) begin : g_bad_ports
        $error("PORTS must match the package port count");
    end

    typedef enum logic [2:0] {
        ST_CAPTURE,
        ST_DECODE,
        ST_EE_LOAD,
        ST_SMB_WAIT,
        ST_READY,
        ST_INVALID
    } hcs_state_t;

    hcs_state_t state_q;
    hcs_state_t state_d;
    hcs_pkg::hcs_method_t method_q;
    hcs_pkg::hcs_method_t method_d;
    hcs_pkg::hcs_straps_t straps_q;
    hcs_pkg::hcs_straps_t pin_d;
    hcs_pkg::hcs_straps_t pin_q;
    hcs_pkg::hcs_feat_t feat_d;
    hcs_pkg::hcs_feat_t feat_q;
    hcs_pkg::hcs_otp_t otp_mode_q;
    hcs_pkg::hcs_tw_t tw_cmd_q;
    logic sda_q;
    logic latched;
    logic [PORTS-1:0] strap_fixed;
    logic [PORTS-1:0] strap_disable;
    logic use_straps;
    logic led_level;
    logic cfg_wr_ok;
    logic smb_end;
    logic vsm_take;
    logic pt_fwd;
    logic cfg_wr_q;
    logic [7:0] cfg_addr_q;
    logic [7:0] cfg_data_q;
    logic ec_q;
    logic resume_q;
    logic hub_reset_q;
    logic pt_en_q;
    logic tw_valid_q;
    logic [7:0] tw_data_q;

    // ************************************************************
    // Strap capture
    // ************************************************************
    hcs_strap_latch #(
        .W(hcs_pkg::STRAP_W + 1)
    ) u_latch (
        .clk(REF_CLK),
        .rst(RST),
        .d({SDA_IN, STRAP_PIN_IN}),
        .q({sda_q, straps_q}),
        .done(latched)
    );

    // Pins float until captured, then carry their normal function
    assign STRAP_PIN_OE = {hcs_pkg::STRAP_W{latched}};
    // Keeper only while undriven, so it never fights our own output
    assign STRAP_PULL_EN = ~STRAP_PIN_OE;
    assign STRAP_PULL_UP = hcs_pkg::STRAP_PULL_UP;

    // ************************************************************
    // Method decode
    // ************************************************************
    assign method_d = (straps_q.cfg_sel == hcs_pkg::SEL_SELF) ? hcs_pkg::HCS_M_SELF :
        (straps_q.cfg_sel == hcs_pkg::SEL_BUS) ? hcs_pkg::HCS_M_BUS :
        !sda_q ? hcs_pkg::HCS_M_INVALID :
        (straps_q.cfg_sel == hcs_pkg::SEL_EEPROM) ? hcs_pkg::HCS_M_EEPROM :
        hcs_pkg::HCS_M_SMB;

    assign cfg_wr_ok = SMB_WR_VALID && !HUB_ATTACHED;
    assign smb_end = cfg_wr_ok && (SMB_WR_ADDR == hcs_pkg::SMB_END_ADDR);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_CAPTURE: begin
                if (latched) begin
                    state_d = ST_DECODE;
                end
            end
            ST_DECODE: begin
                unique case (method_d)
                    hcs_pkg::HCS_M_EEPROM: state_d = ST_EE_LOAD;
                    hcs_pkg::HCS_M_SMB: state_d = ST_SMB_WAIT;
                    hcs_pkg::HCS_M_INVALID: state_d = ST_INVALID;
                    default: state_d = ST_READY;
                endcase
            end
            ST_EE_LOAD: begin
                if (EE_LOAD_DONE) begin
                    state_d = ST_READY;
                end
            end
            ST_SMB_WAIT: begin
                // No timeout: the master decides when setup is over
                if (smb_end) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: state_d = ST_READY;
            ST_INVALID: state_d = ST_INVALID;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_CAPTURE;
            method_q <= hcs_pkg::HCS_M_NONE;
        end else begin
            state_q <= state_d;
            if (state_q == ST_DECODE) begin
                method_q <= method_d;
            end
        end
    end

    assign CFG_METHOD = method_q;
    assign EE_LOAD_REQ = (state_q == ST_EE_LOAD);
    assign SMB_CFG_WAIT = (state_q == ST_SMB_WAIT);
    assign CFG_DONE = (state_q == ST_READY);
    assign CFG_INVALID = (state_q == ST_INVALID);

    // ************************************************************
    // Feature decode
    // ************************************************************
    // EEPROM and SMBus setups take all features from the register, not the straps
    assign use_straps = (method_q == hcs_pkg::HCS_M_SELF) ||
        (method_q == hcs_pkg::HCS_M_BUS);
    assign STRAPS_USED = use_straps;

    for (genvar i = 0; i < PORTS; i++) begin : g_port
        assign strap_fixed[i] = straps_q.fixed_port_count_strap > 2'(i);
        assign strap_disable[i] = straps_q.port_minus_line_disable[i] &
            straps_q.port_plus_line_disable[i];
    end

    assign feat_d = '{
        self_powered: use_straps ? (method_q == hcs_pkg::HCS_M_SELF) :
            CFG_REG_FEAT.self_powered,
        fixed_port: (use_straps && !LOCAL_POWER_DETECT) ? strap_fixed :
            CFG_REG_FEAT.fixed_port,
        charge_support: use_straps ? straps_q.downstream_charge_enable_strap :
            CFG_REG_FEAT.charge_support,
        port_disable: use_straps ? strap_disable : CFG_REG_FEAT.port_disable
    };

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            feat_q <= '0;
        end else if (state_q == ST_READY) begin
            feat_q <= feat_d;
        end
    end

    assign FEATURES = feat_q;

    // ************************************************************
    // Pin outputs in normal operation
    // ************************************************************
    // Odd fixed codes mean the lamp is wired active low
    assign led_level = SUSPEND_ACTIVE ^ straps_q.fixed_port_count_strap[0];
    assign pin_d = '{
        cfg_sel: FUNC_OUT.cfg_sel,
        fixed_port_count_strap: {FUNC_OUT.fixed_port_count_strap[1], led_level},
        downstream_charge_enable_strap: FUNC_OUT.downstream_charge_enable_strap,
        port_minus_line_disable: FUNC_OUT.port_minus_line_disable,
        port_plus_line_disable: FUNC_OUT.port_plus_line_disable
    };

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pin_q <= hcs_pkg::STRAP_RST;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign STRAP_PIN_OUT = pin_q;

    // ************************************************************
    // SMBus configuration writes
    // ************************************************************
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cfg_wr_q <= 1'b0;
            cfg_addr_q <= 8'h00;
            cfg_data_q <= 8'h00;
        end else begin
            cfg_wr_q <= cfg_wr_ok;
            if (cfg_wr_ok) begin
                cfg_addr_q <= SMB_WR_ADDR;
                cfg_data_q <= SMB_WR_DATA;
            end
        end
    end

    assign CFG_WR_VALID = cfg_wr_q;
    assign CFG_WR_ADDR = cfg_addr_q;
    assign CFG_WR_DATA = cfg_data_q;

    // ************************************************************
    // Vendor messages and OTP mode
    // ************************************************************
    assign vsm_take = VSM_VALID && !VSM_BLOCK;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ec_q <= hcs_pkg::EC_ENABLE_RST;
            resume_q <= hcs_pkg::RESUME_ENABLE_RST;
            hub_reset_q <= 1'b0;
        end else begin
            hub_reset_q <= vsm_take && (VSM_CMD == hcs_pkg::HCS_VSM_HUB_RESET);
            if (vsm_take) begin
                unique case (VSM_CMD)
                    hcs_pkg::HCS_VSM_EC_ENABLE: ec_q <= 1'b1;
                    hcs_pkg::HCS_VSM_EC_DISABLE: ec_q <= 1'b0;
                    hcs_pkg::HCS_VSM_RESUME_ENABLE: resume_q <= 1'b1;
                    hcs_pkg::HCS_VSM_RESUME_DISABLE: resume_q <= 1'b0;
                    default: ;
                endcase
            end
        end
    end

    assign EC_ENABLE = ec_q;
    assign SPECIAL_RESUME = resume_q;
    assign HUB_RESET_REQ = hub_reset_q;

    // The USB path has no way to select the robust modes
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            otp_mode_q <= hcs_pkg::HCS_OTP_SINGLE;
        end else if (OTP_MODE_SET) begin
            otp_mode_q <= OTP_FROM_USB ? hcs_pkg::HCS_OTP_SINGLE : OTP_MODE_REQ;
        end
    end

    assign OTP_MODE = otp_mode_q;

    // ************************************************************
    // Two-wire passthrough
    // ************************************************************
    assign pt_fwd = PT_VALID && pt_en_q && (PT_CMD != hcs_pkg::HCS_TW_PASS_ENABLE) &&
        (PT_CMD != hcs_pkg::HCS_TW_PASS_DISABLE);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pt_en_q <= hcs_pkg::PASS_ENABLE_RST;
            tw_valid_q <= 1'b0;
            tw_cmd_q <= hcs_pkg::HCS_TW_STOP;
            tw_data_q <= 8'h00;
        end else begin
            if (PT_VALID && (PT_CMD == hcs_pkg::HCS_TW_PASS_ENABLE)) begin
                pt_en_q <= 1'b1;
            end else if (PT_VALID && (PT_CMD == hcs_pkg::HCS_TW_PASS_DISABLE)) begin
                pt_en_q <= 1'b0;
            end
            tw_valid_q <= pt_fwd;
            if (pt_fwd) begin
                tw_cmd_q <= PT_CMD;
                tw_data_q <= PT_DATA;
            end
        end
    end

    assign PT_ENABLED = pt_en_q;
    assign TW_VALID = tw_valid_q;
    assign TW_CMD = tw_cmd_q;
    assign TW_DATA = tw_data_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_pins_float;
        @(posedge REF_CLK) disable iff (RST)
        !latched |-> (STRAP_PIN_OE == '0) && (STRAP_PULL_EN == '1);
    endproperty
    a_pins_float: assert property (p_pins_float)
        else $error("strap pins driven before capture");

    property p_straps_frozen;
        @(posedge REF_CLK) disable iff (RST)
        latched ##1 latched |-> $stable(straps_q) && $stable(sda_q);
    endproperty
    a_straps_frozen: assert property (p_straps_frozen)
        else $error("captured straps changed");

    property p_self_route;
        @(posedge REF_CLK) disable iff (RST)
        (state_q == ST_DECODE) && (straps_q.cfg_sel == hcs_pkg::SEL_SELF) |=>
            (method_q == hcs_pkg::HCS_M_SELF) && CFG_DONE ##1 FEATURES.self_powered;
    endproperty
    a_self_route: assert property (p_self_route)
        else $error("self-powered select not honoured");

    property p_bus_route;
        @(posedge REF_CLK) disable iff (RST)
        (state_q == ST_DECODE) && (straps_q.cfg_sel == hcs_pkg::SEL_BUS) |=>
            CFG_DONE ##1 !FEATURES.self_powered && STRAPS_USED;
    endproperty
    a_bus_route: assert property (p_bus_route)
        else $error("bus-powered select not honoured");

    property p_eeprom_route;
        @(posedge REF_CLK) disable iff (RST)
        (state_q == ST_DECODE) && sda_q && (straps_q.cfg_sel == hcs_pkg::SEL_EEPROM) |=>
            EE_LOAD_REQ && !STRAPS_USED && !SMB_CFG_WAIT;
    endproperty
    a_eeprom_route: assert property (p_eeprom_route)
        else $error("eeprom select not honoured");

    property p_smb_route;
        @(posedge REF_CLK) disable iff (RST)
        (state_q == ST_DECODE) && (straps_q.cfg_sel == hcs_pkg::SEL_SMB) |=>
            (sda_q ? SMB_CFG_WAIT : CFG_INVALID) && !STRAPS_USED;
    endproperty
    a_smb_route: assert property (p_smb_route)
        else $error("smbus select not honoured");

    property p_attach_blocks;
        @(posedge REF_CLK) disable iff (RST)
        SMB_WR_VALID && HUB_ATTACHED |=> !CFG_WR_VALID;
    endproperty
    a_attach_blocks: assert property (p_attach_blocks)
        else $error("config write passed after attach");

    property p_led_polarity;
        @(posedge REF_CLK) disable iff (RST)
        latched |=> STRAP_PIN_OUT.fixed_port_count_strap[0] ==
            ($past(SUSPEND_ACTIVE) ^ straps_q.fixed_port_count_strap[0]);
    endproperty
    a_led_polarity: assert property (p_led_polarity)
        else $error("suspend led polarity wrong");

    property p_usb_otp;
        @(posedge REF_CLK) disable iff (RST)
        OTP_MODE_SET && OTP_FROM_USB |=> OTP_MODE == hcs_pkg::HCS_OTP_SINGLE;
    endproperty
    a_usb_otp: assert property (p_usb_otp)
        else $error("usb otp mode not single-ended");

    property p_pass_data;
        @(posedge REF_CLK) disable iff (RST)
        PT_VALID && pt_en_q && (PT_CMD == hcs_pkg::HCS_TW_WRITE) |=>
            TW_VALID && (TW_DATA == $past(PT_DATA)) && (TW_CMD == hcs_pkg::HCS_TW_WRITE);
    endproperty
    a_pass_data: assert property (p_pass_data)
        else $error("passthrough write lost");

    property p_vsm_reset;
        @(posedge REF_CLK) disable iff (RST)
        VSM_VALID && !VSM_BLOCK && (VSM_CMD == hcs_pkg::HCS_VSM_HUB_RESET) |=>
            HUB_RESET_REQ ##1 !HUB_RESET_REQ || $past(VSM_VALID);
    endproperty
    a_vsm_reset: assert property (p_vsm_reset)
        else $error("hub reset message not taken");

    property p_fixed_decode;
        @(posedge REF_CLK) disable iff (RST)
        CFG_DONE && STRAPS_USED && !LOCAL_POWER_DETECT |=>
            FEATURES.fixed_port[0] == (straps_q.fixed_port_count_strap != 2'h0);
    endproperty
    a_fixed_decode: assert property (p_fixed_decode)
        else $error("fixed port decode wrong");

endmodule

// ==== tb/hcs_cfg_partner.sv ====
// Behavioural EEPROM loader and SMBus master facing the strap selector
`timescale 1ns/1ps
module hcs_cfg_partner #(
    parameter int DELAY = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ee_req,
    input wire logic smb_wait,
    output logic ee_done,
    output logic wr_valid,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);
    logic [7:0] cnt;
    logic fire;
    assign fire = (cnt == 8'(DELAY));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            ee_done <= 1'b0;
            wr_valid <= 1'b0;
            wr_addr <= 8'h5a;
            wr_data <= 8'ha5;
        end else begin
            cnt <= (ee_req || smb_wait) ? cnt + 8'h01 : 8'h00;
            ee_done <= ee_req && fire;
            wr_valid <= smb_wait && fire;
            // Idle bus lines keep changing so stale values never look valid
            wr_addr <= (smb_wait && fire) ? hcs_pkg::SMB_END_ADDR : ~wr_addr;
            wr_data <= ~wr_data;
        end
    end
endmodule

// ==== tb/test_hub_config_strap_select.sv ====
// Self-checking testbench for the hub strap configuration selector
`timescale 1ns/1ps
module test_hub_config_strap_select;
    typedef struct packed {
        logic [1:0] sel;
        logic sda;
        logic [1:0] fix;
        logic lpd;
        logic att;
        hcs_pkg::hcs_method_t m;
    } hcs_row_t;
    logic clk = 0, rst = 1, sda = 0, lpd = 0, att = 0, vv = 0, vb = 0, os = 0, ou = 0, pv = 0;
    logic sa = 0;
    logic ee_done, ee_req, smb_wait, done, used, inv, wv, ec, sres, hrr, pten, twv;
    logic [7:0] wa, wd, twd, cwa, pd = 8'h00;
    logic [12:0] oe, pen, pup;
    hcs_pkg::hcs_straps_t strap = 13'h0000, pin_in, pin_out;
    hcs_pkg::hcs_vsm_t vc = hcs_pkg::HCS_VSM_EC_ENABLE;
    hcs_pkg::hcs_otp_t oreq = hcs_pkg::HCS_OTP_SINGLE, omode;
    hcs_pkg::hcs_tw_t pc = hcs_pkg::HCS_TW_STOP, twc;
    hcs_pkg::hcs_method_t meth;
    hcs_pkg::hcs_feat_t feat, fe, reg_feat = 10'h2a5;
    int num_errors = 0, comparisons = 0;
    hcs_row_t r;
    hcs_row_t rows[10] = '{
        '{2'h0, 1'b0, 2'h0, 1'b0, 1'b0, hcs_pkg::HCS_M_SELF},
        '{2'h0, 1'b1, 2'h1, 1'b0, 1'b0, hcs_pkg::HCS_M_SELF},
        '{2'h2, 1'b0, 2'h2, 1'b0, 1'b0, hcs_pkg::HCS_M_BUS},
        '{2'h2, 1'b1, 2'h3, 1'b0, 1'b0, hcs_pkg::HCS_M_BUS},
        '{2'h0, 1'b0, 2'h3, 1'b1, 1'b0, hcs_pkg::HCS_M_SELF},
        '{2'h3, 1'b1, 2'h1, 1'b0, 1'b0, hcs_pkg::HCS_M_EEPROM},
        '{2'h1, 1'b1, 2'h2, 1'b0, 1'b0, hcs_pkg::HCS_M_SMB},
        '{2'h1, 1'b0, 2'h0, 1'b0, 1'b0, hcs_pkg::HCS_M_INVALID},
        '{2'h3, 1'b0, 2'h0, 1'b0, 1'b0, hcs_pkg::HCS_M_INVALID},
        '{2'h1, 1'b1, 2'h0, 1'b0, 1'b1, hcs_pkg::HCS_M_SMB}};

    // Board only pulls the pins; the device wins whenever it drives
    assign pin_in = (oe & pin_out) | (~oe & strap);

    initial begin
        forever #20 clk = ~clk;
    end

    hcs_strap_select DUT (.REF_CLK(clk), .RST(rst), .STRAP_PIN_IN(pin_in),
        .STRAP_PIN_OUT(pin_out), .STRAP_PIN_OE(oe), .STRAP_PULL_EN(pen), .STRAP_PULL_UP(pup),
        .SDA_IN(sda), .FUNC_OUT(strap), .SUSPEND_ACTIVE(sa), .LOCAL_POWER_DETECT(lpd),
        .CFG_REG_FEAT(reg_feat), .EE_LOAD_DONE(ee_done), .CFG_METHOD(meth),
        .EE_LOAD_REQ(ee_req), .SMB_CFG_WAIT(smb_wait), .CFG_DONE(done), .CFG_INVALID(inv),
        .STRAPS_USED(used), .FEATURES(feat), .HUB_ATTACHED(att), .SMB_WR_VALID(wv),
        .SMB_WR_ADDR(wa), .SMB_WR_DATA(wd), .CFG_WR_VALID(), .CFG_WR_ADDR(cwa),
        .CFG_WR_DATA(), .VSM_VALID(vv), .VSM_CMD(vc), .VSM_BLOCK(vb), .EC_ENABLE(ec),
        .SPECIAL_RESUME(sres), .HUB_RESET_REQ(hrr), .OTP_MODE_SET(os), .OTP_FROM_USB(ou),
        .OTP_MODE_REQ(oreq), .OTP_MODE(omode), .PT_VALID(pv), .PT_CMD(pc), .PT_DATA(pd),
        .PT_ENABLED(pten), .TW_VALID(twv), .TW_CMD(twc), .TW_DATA(twd));

    hcs_cfg_partner #(.DELAY(3)) PARTNER (.clk(clk), .rst(rst), .ee_req(ee_req),
        .smb_wait(smb_wait), .ee_done(ee_done), .wr_valid(wv), .wr_addr(wa), .wr_data(wd));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            @(posedge clk);
            rst <= 1'b1;
            strap <= {r.sel, r.fix, 3'h5, 3'h3, 3'h6};
            sda <= r.sda;
            lpd <= r.lpd;
            att <= r.att;
            sa <= i[0];
            repeat (i == 0 ? 10 : 3) @(posedge clk);
            #1 chk("oe", 16'h0, oe);
            chk("pull", 16'h1fff, pen);
            chk("pull dir", hcs_pkg::STRAP_PULL_UP, pup);
            @(posedge clk);
            rst <= 1'b0;
            repeat (3) @(posedge clk);
            #1 chk("method", r.m, meth);
            chk("oe on", 16'h1fff, oe);
            chk("pull off", 16'h0, pen);
            chk("ee req", r.m == hcs_pkg::HCS_M_EEPROM, ee_req);
            strap <= ~strap;
            sda <= ~sda;
            repeat (12) @(posedge clk);
            fe = {r.sel == hcs_pkg::SEL_SELF, r.fix == 2'h3, r.fix[1], r.fix != 2'h0, 6'h2a};
            if (r.lpd) fe.fixed_port = reg_feat.fixed_port;
            // Select bit 0 high means straps are ignored
            if (r.sel[0]) fe = reg_feat;
            #1 chk("done", r.m != hcs_pkg::HCS_M_INVALID && !r.att, done);
            chk("invalid", r.m == hcs_pkg::HCS_M_INVALID, inv);
            chk("used", !r.sel[0], used);
            chk("smb wait", r.m == hcs_pkg::HCS_M_SMB && r.att, smb_wait);
            chk("cfg addr", r.m == hcs_pkg::HCS_M_SMB && !r.att ? 8'hff : 8'h0,
                cwa);
            if (r.m != hcs_pkg::HCS_M_INVALID && !r.att) begin
                chk("feat", fe, feat);
            end
            chk("led", r.fix[0] ? !i[0] : i[0], pin_out.fixed_port_count_strap[0]);
            $display("Row %0d done", i);
        end
        @(posedge clk);
        vv <= 1'b1;
        @(posedge clk);
        vc <= hcs_pkg::HCS_VSM_EC_DISABLE;
        vb <= 1'b1;
        #1 chk("ec", 16'h1, ec);
        @(posedge clk);
        vc <= hcs_pkg::HCS_VSM_HUB_RESET;
        vb <= 1'b0;
        @(posedge clk);
        vc <= hcs_pkg::HCS_VSM_RESUME_ENABLE;
        #1 chk("ec blocked", 16'h1, ec);
        chk("hub reset", 16'h1, hrr);
        @(posedge clk);
        vv <= 1'b0;
        os <= 1'b1;
        oreq <= hcs_pkg::HCS_OTP_REDUNDANT;
        #1 chk("hub reset end", 16'h0, hrr);
        chk("resume", 16'h1, sres);
        @(posedge clk);
        ou <= 1'b1;
        oreq <= hcs_pkg::HCS_OTP_DIFF;
        #1 chk("otp smb", hcs_pkg::HCS_OTP_REDUNDANT, omode);
        @(posedge clk);
        os <= 1'b0;
        pv <= 1'b1;
        pc <= hcs_pkg::HCS_TW_WRITE;
        pd <= 8'h3c;
        #1 chk("otp usb", hcs_pkg::HCS_OTP_SINGLE, omode);
        @(posedge clk);
        pc <= hcs_pkg::HCS_TW_PASS_ENABLE;
        #1 chk("tw dropped", 16'h0, twv);
        @(posedge clk);
        pc <= hcs_pkg::HCS_TW_WRITE;
        pd <= 8'hc3;
        #1 chk("pt on", 16'h1, pten);
        @(posedge clk);
        pc <= hcs_pkg::HCS_TW_PASS_DISABLE;
        #1 chk("tw valid", 16'h1, twv);
        chk("tw cmd", hcs_pkg::HCS_TW_WRITE, twc);
        chk("tw data", 16'hc3, twd);
        @(posedge clk);
        pc <= hcs_pkg::HCS_TW_STOP;
        #1 chk("pt off", 16'h0, pten);
        @(posedge clk);
        pv <= 1'b0;
        #1 chk("tw off", 16'h0, twv);
        $display("Command tests done");
        give_verdict();
    end
endmodule
